// File: rtl/make_break_timer.sv
`default_nettype none

module make_break_timer
  import setpoint_pkg::*;
#(
  parameter int DELAY_WIDTH = DELAY_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample,
  input wire logic cond,
  input wire logic second_tick,
  input wire logic [DELAY_WIDTH-1:0] make_delay,
  input wire logic [DELAY_WIDTH-1:0] break_delay,
  output logic active
);

  logic cond_q;
  logic [DELAY_WIDTH-1:0] elapsed;
  logic [DELAY_WIDTH-1:0] limit;

  assign limit = cond_q ? make_delay : break_delay;

  // condition only moves on a finished conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= 1'b0;
    end else if (sample) begin
      cond_q <= cond;
    end
  end

  // whole-second ticks are free running, so a delay may run short by
  // up to one second; kept to avoid a divider per pending change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      elapsed <= '0;
    end else if (cond_q == active) begin
      elapsed <= '0;
    end else if (elapsed >= limit) begin
      active <= cond_q;
      elapsed <= '0;
    end else if (second_tick) begin
      elapsed <= elapsed + 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: rtl/setpoint_pkg.sv
`default_nettype none

package setpoint_pkg;

  //////////////////////////////////////////////////////////////////////////
  // widths
  localparam int READING_W = 16;
  localparam int LEVEL_W = 16;
  localparam int DELAY_W = 14;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int NUM_SP = 4;
  localparam int IRQ_W = 3;

  //////////////////////////////////////////////////////////////////////////
  // register word indices (byte address is four times the index)
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SETPOINT_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_SETPOINT_TWO = 4'h2;
  localparam logic [ADDR_W-1:0] REG_SETPOINT_THREE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SETPOINT_FOUR = 4'h4;
  localparam logic [ADDR_W-1:0] REG_MAKE_DELAY = 4'h5;
  localparam logic [ADDR_W-1:0] REG_BREAK_DELAY = 4'h6;
  localparam logic [ADDR_W-1:0] REG_SPAN_HIGH = 4'h7;
  localparam logic [ADDR_W-1:0] REG_SPAN_LOW = 4'h8;
  localparam logic [ADDR_W-1:0] REG_OUTPUT_LOW = 4'h9;
  localparam logic [ADDR_W-1:0] REG_OUTPUT_HIGH = 4'ha;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hb;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'hc;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hd;

  //////////////////////////////////////////////////////////////////////////
  // control fields
  localparam int CTRL_BAND_BIT = 0;
  localparam int CTRL_VOLT_BIT = 1;
  localparam int CTRL_PATTERN_LSB = 4;
  localparam int PATTERN_W = 4;

  // pattern bit 3 is the leftmost character, i.e. setpoint one; 1 = high
  localparam logic [PATTERN_W-1:0] PATTERN_LLLL = 4'h0;
  localparam logic [PATTERN_W-1:0] PATTERN_LHLH = 4'h5;
  localparam logic [PATTERN_W-1:0] PATTERN_LHHH = 4'h7;
  localparam logic [PATTERN_W-1:0] PATTERN_HHHH = 4'hf;

  // status fields
  localparam int STAT_RELAY_LSB = 0;
  localparam int STAT_IND_LSB = 4;
  localparam int STAT_PRESENT_BIT = 8;
  localparam int STAT_READING_LSB = 16;

  // interrupt events
  localparam int IRQ_RELAY_CHANGE = 0;
  localparam int IRQ_BAD_PATTERN = 1;
  localparam int IRQ_BAD_LEVEL = 2;

  //////////////////////////////////////////////////////////////////////////
  // limits and reset values; level codes are 1 uA or 1 mV per count
  localparam logic [DELAY_W-1:0] DELAY_MAX_S = 14'h270f;
  localparam logic [LEVEL_W-1:0] CURRENT_HIGH_MIN = 16'h4650;
  localparam logic [LEVEL_W-1:0] CURRENT_HIGH_MAX = 16'h5dc0;
  localparam logic [LEVEL_W-1:0] VOLT_HIGH_MIN = 16'h1f40;
  localparam logic [LEVEL_W-1:0] VOLT_HIGH_MAX = 16'h283c;
  localparam logic [LEVEL_W-1:0] LEVEL_STAGE_MAX = 16'hffff;
  localparam logic [LEVEL_W-1:0] OUTPUT_LOW_RESET = 16'h0fa0;
  localparam logic [LEVEL_W-1:0] OUTPUT_HIGH_RESET = 16'h4e20;
  localparam logic [READING_W-1:0] SPAN_HIGH_RESET = 16'h270f;
  localparam logic [READING_W-1:0] SPAN_LOW_RESET = 16'h0000;
  localparam logic [READING_W-1:0] SETPOINT_RESET = 16'h270f;
  localparam logic [1:0] STARTUP_SYNC_CYCLES = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint SECOND_NS = 1000000000;
  localparam int CYCLES_PER_SECOND = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage

`default_nettype wire

// File: rtl/setpoint_relay_controller.sv
// Summary of operation
// - relay one makes after alarm holds continuously for make delay, less up to one second.
// - relay one breaks after non-alarm holds for break delay, less up to one second.
// - band mode with setpoint two above one forms band one to two.
// - band with low pattern: on below setpoint one, off at two.
// - band with high pattern: on above setpoint two, off at one.
// - high setpoint energizes its relay when reading exceeds the setpoint.
// - low setpoint energizes its relay when reading is below setpoint.
// - pattern characters left to right belong to setpoints one to four.
// - only patterns LLLL, LhLh, Lhhh and hhhh are accepted.
// - setpoints two to four switch at once, without any delay.
// - all four setpoints are evaluated and indicated, relays fitted or not.
// - analog level scales linearly from low to high across the span.
// - span points in reverse order give the inverted output relation.
// - outside the span the analog level never drops below the low level.
// - outside the span the level may rise past high up to stage maximum.
// - high level checked against the mode limits only when written; always above the low level.
// - analog module presence caught at power-up; absent skips level setting.
`default_nettype none

module setpoint_relay_controller
  import setpoint_pkg::*;
#(
  parameter int SECOND_CYCLES = CYCLES_PER_SECOND
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reading_valid,
  input wire logic [READING_W-1:0] reading,
  input wire logic module_present_pin,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [NUM_SP-1:0] relay_out,
  output logic [NUM_SP-1:0] indicator,
  output logic [LEVEL_W-1:0] analog_level,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic over_setpoint(
    input logic signed [READING_W-1:0] r,
    input logic signed [READING_W-1:0] s,
    input logic high
  );
    return high ? (r > s) : (r < s);
  endfunction

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] be
  );
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic signed [READING_W-1:0] setpoint [NUM_SP];
  logic band_mode_enable;
  logic volt_mode;
  logic [PATTERN_W-1:0] relay_direction_pattern;
  logic [DELAY_W-1:0] make_delay;
  logic [DELAY_W-1:0] break_delay;
  logic signed [READING_W-1:0] span_high_point;
  logic signed [READING_W-1:0] span_low_point;
  logic [LEVEL_W-1:0] output_low_level;
  logic [LEVEL_W-1:0] output_high_level;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [READING_W-1:0] last_reading;

  logic present_meta;
  logic present_sync;
  logic [1:0] startup_cnt;
  logic module_present;

  logic [31:0] tick_cnt;
  logic second_tick;

  logic band_active;
  logic band_latch;
  logic next_band;
  logic cond_one;
  logic timer_active;
  logic [NUM_SP-1:1] alarm_q;
  logic [NUM_SP-1:0] next_relay;

  logic wr_go;
  logic rd_go;
  logic [15:0] wd16;
  logic pattern_ok;
  logic [LEVEL_W-1:0] high_min;
  logic [LEVEL_W-1:0] high_max;
  logic [LEVEL_W-1:0] high_cand;
  logic [LEVEL_W-1:0] low_cand;

  ////////////////////////////////////////////////////////////////////////////
  // module presence, sampled once after reset release

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      present_meta <= 1'b0;
      present_sync <= 1'b0;
    end else begin
      present_meta <= module_present_pin;
      present_sync <= present_meta;
    end
  end

  // later changes on the pin are ignored: swapping needs a reset to sample the pin again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_cnt <= '0;
      module_present <= 1'b0;
    end else if (startup_cnt != STARTUP_SYNC_CYCLES) begin
      startup_cnt <= startup_cnt + 1'b1;
      if (startup_cnt == STARTUP_SYNC_CYCLES - 2'h1) begin
        module_present <= present_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one second tick for the delay timer

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      second_tick <= 1'b0;
    end else if (tick_cnt >= 32'(SECOND_CYCLES - 1)) begin
      tick_cnt <= '0;
      second_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      second_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint one with optional band

  assign band_active = band_mode_enable &&
                       (setpoint[1] > setpoint[0]);

  always_comb begin
    if (relay_direction_pattern[3]) begin
      // emptying: on above two, held until back down to one
      next_band = band_latch ? ($signed(reading) > setpoint[0])
                             : ($signed(reading) > setpoint[1]);
    end else begin
      // filling: on below one, held until up to two
      next_band = band_latch ? ($signed(reading) < setpoint[1])
                             : ($signed(reading) < setpoint[0]);
    end
    cond_one = band_active ? next_band
             : over_setpoint(reading, setpoint[0],
                             relay_direction_pattern[3]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      band_latch <= 1'b0;
    end else if (reading_valid) begin
      band_latch <= band_active ? next_band : 1'b0;
    end
  end

  make_break_timer #(
    .DELAY_WIDTH(DELAY_W)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .sample(reading_valid),
    .cond(cond_one),
    .second_tick(second_tick),
    .make_delay(make_delay),
    .break_delay(break_delay),
    .active(timer_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // setpoints two to four, no delay

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= '0;
    end else if (reading_valid) begin
      for (int i = 1; i < NUM_SP; i++) begin
        // pattern bit 3-i carries setpoint i+1's character
        alarm_q[i] <= over_setpoint(reading, setpoint[i],
          relay_direction_pattern[3-i]);
      end
    end
  end

  assign next_relay = {alarm_q, timer_active};

  // indicators follow relays whether or not a relay is fitted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_out <= '0;
      indicator <= '0;
    end else begin
      relay_out <= next_relay;
      indicator <= next_relay;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog output scaling

  logic signed [16:0] offset;
  logic signed [16:0] span;
  logic signed [16:0] range_w;
  logic signed [34:0] prod;
  logic signed [34:0] quot;
  logic signed [34:0] level_wide;
  logic [LEVEL_W-1:0] next_level;

  always_comb begin
    offset = {reading[15], reading} -
             {span_low_point[15], span_low_point};
    span = {span_high_point[15], span_high_point} -
           {span_low_point[15], span_low_point};
    range_w = $signed({1'b0, output_high_level}) -
              $signed({1'b0, output_low_level});
    prod = 35'(offset) * 35'(range_w);
    // a negative span flips the quotient sign: reversed points invert
    quot = (span == 17'sh0) ? 35'sh0 : prod / 35'(span);
    level_wide = $signed({19'h0, output_low_level}) + quot;
    if (quot < 35'sh0) begin
      next_level = output_low_level;
    end else if (level_wide > $signed({19'h0, LEVEL_STAGE_MAX})) begin
      next_level = LEVEL_STAGE_MAX;
    end else begin
      next_level = level_wide[LEVEL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_level <= '0;
    end else if (!module_present) begin
      analog_level <= '0;
    end else if (reading_valid) begin
      analog_level <= next_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every access

  assign wr_go = write && !waitrequest;
  assign rd_go = read && waitrequest;
  assign wd16 = merge16(16'h0000, writedata, byteenable);
  assign pattern_ok = writedata[CTRL_PATTERN_LSB +: PATTERN_W] inside
                      {PATTERN_LLLL, PATTERN_LHLH, PATTERN_LHHH, PATTERN_HHHH};
  assign high_min = volt_mode ? VOLT_HIGH_MIN : CURRENT_HIGH_MIN;
  assign high_max = volt_mode ? VOLT_HIGH_MAX : CURRENT_HIGH_MAX;
  assign high_cand = merge16(output_high_level, writedata, byteenable);
  assign low_cand = merge16(output_low_level, writedata, byteenable);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= '0;
    end else if (rd_go) begin
      case (address)
        REG_CONTROL: readdata <= 32'({relay_direction_pattern, 2'b00,
                                      volt_mode, band_mode_enable});
        REG_SETPOINT_ONE: readdata <= 32'(setpoint[0]);
        REG_SETPOINT_TWO: readdata <= 32'(setpoint[1]);
        REG_SETPOINT_THREE: readdata <= 32'(setpoint[2]);
        REG_SETPOINT_FOUR: readdata <= 32'(setpoint[3]);
        REG_MAKE_DELAY: readdata <= 32'(make_delay);
        REG_BREAK_DELAY: readdata <= 32'(break_delay);
        REG_SPAN_HIGH: readdata <= 32'(span_high_point);
        REG_SPAN_LOW: readdata <= 32'(span_low_point);
        REG_OUTPUT_LOW: readdata <= 32'(output_low_level);
        REG_OUTPUT_HIGH: readdata <= 32'(output_high_level);
        REG_STATUS: readdata <= {last_reading, 7'h00, module_present,
                                 indicator, relay_out};
        REG_IRQ_STATUS: readdata <= 32'(irq_status);
        REG_IRQ_MASK: readdata <= 32'(irq_mask);
        default: readdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      band_mode_enable <= 1'b0;
      volt_mode <= 1'b0;
      relay_direction_pattern <= PATTERN_HHHH;
      setpoint[0] <= SETPOINT_RESET;
      setpoint[1] <= SETPOINT_RESET;
      setpoint[2] <= SETPOINT_RESET;
      setpoint[3] <= SETPOINT_RESET;
      make_delay <= '0;
      break_delay <= '0;
      span_high_point <= SPAN_HIGH_RESET;
      span_low_point <= SPAN_LOW_RESET;
      output_low_level <= OUTPUT_LOW_RESET;
      output_high_level <= OUTPUT_HIGH_RESET;
      irq_mask <= '0;
    end else if (wr_go) begin
      case (address)
        REG_CONTROL: begin
          if (byteenable[0]) begin
            band_mode_enable <= writedata[CTRL_BAND_BIT];
            volt_mode <= writedata[CTRL_VOLT_BIT];
            if (pattern_ok) begin
              relay_direction_pattern <=
                writedata[CTRL_PATTERN_LSB +: PATTERN_W];
            end
          end
        end
        REG_SETPOINT_ONE: setpoint[0] <= merge16(setpoint[0], writedata,
                                                 byteenable);
        REG_SETPOINT_TWO: setpoint[1] <= merge16(setpoint[1], writedata,
                                                 byteenable);
        REG_SETPOINT_THREE: setpoint[2] <= merge16(setpoint[2], writedata,
                                                   byteenable);
        REG_SETPOINT_FOUR: setpoint[3] <= merge16(setpoint[3], writedata,
                                                  byteenable);
        REG_MAKE_DELAY: begin
          if (wd16[DELAY_W-1:0] <= DELAY_MAX_S && wd16[15:DELAY_W] == '0) begin
            make_delay <= wd16[DELAY_W-1:0];
          end
        end
        REG_BREAK_DELAY: begin
          if (wd16[DELAY_W-1:0] <= DELAY_MAX_S && wd16[15:DELAY_W] == '0) begin
            break_delay <= wd16[DELAY_W-1:0];
          end
        end
        REG_SPAN_HIGH: span_high_point <= merge16(span_high_point,
                                                  writedata, byteenable);
        REG_SPAN_LOW: span_low_point <= merge16(span_low_point,
                                                writedata, byteenable);
        REG_OUTPUT_LOW: begin
          if (module_present && low_cand < output_high_level) begin
            output_low_level <= low_cand;
          end
        end
        REG_OUTPUT_HIGH: begin
          if (module_present && high_cand >= high_min &&
              high_cand <= high_max && high_cand > output_low_level) begin
            output_high_level <= high_cand;
          end
        end
        REG_IRQ_MASK: irq_mask <= writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and interrupt

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reading <= '0;
    end else if (reading_valid) begin
      last_reading <= reading;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_RELAY_CHANGE] = (next_relay != relay_out);
    irq_event[IRQ_BAD_PATTERN] = wr_go && address == REG_CONTROL &&
                                 byteenable[0] && !pattern_ok;
    irq_event[IRQ_BAD_LEVEL] = wr_go &&
      ((address == REG_OUTPUT_HIGH && (!module_present ||
        high_cand < high_min || high_cand > high_max ||
        high_cand <= output_low_level)) ||
       (address == REG_OUTPUT_LOW && (!module_present ||
        low_cand >= output_high_level)));
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (wr_go && address == REG_IRQ_STATUS && byteenable[0]) begin
      irq_status <= (irq_status & ~writedata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

`default_nettype wire

// File: verification/conversion_source.sv
`default_nettype none

module conversion_source
  import setpoint_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [READING_W-1:0] value,
  input wire logic fitted,
  output logic reading_valid,
  output logic [READING_W-1:0] reading,
  output logic module_present_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign module_present_pin = fitted;
  // outside a result the code toggles, so a held stale value cannot pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reading_valid <= 1'b0;
      reading <= '0;
    end else begin
      reading_valid <= go;
      reading <= go ? value : ~reading;
    end
  end
endmodule

`default_nettype wire

// File: verification/setpoint_relay_controller_properties.sv
`default_nettype none

module setpoint_relay_controller_properties
  import setpoint_pkg::*;
#(
  parameter int SECOND_CYCLES = CYCLES_PER_SECOND
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reading_valid,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic [NUM_SP-1:0] relay_out,
  input wire logic [NUM_SP-1:0] indicator,
  input wire logic [LEVEL_W-1:0] analog_level,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property ((read || write) && waitrequest
    |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ack_needs_req: assert property (!waitrequest |-> (read || write))
    else $error("acknowledge without a request");
  a_idle_no_ack: assert property (!(read || write) |=> waitrequest)
    else $error("acknowledge after an idle cycle");
  a_readdata_hold: assert property ($changed(readdata)
    |-> $past(read && waitrequest))
    else $error("read data moved without a read");
  a_lamp_mirror: assert property (indicator == relay_out)
    else $error("indicator differs from relay drive");
  a_fast_relay_paced: assert property ($changed(relay_out[3:1])
    |-> $past(reading_valid, 2))
    else $error("relays four to two moved off the reading pace");
  a_level_paced: assert property ($changed(analog_level)
    |-> $past(reading_valid))
    else $error("analog level moved off the reading pace");

  c_write_ack: cover property (write && !waitrequest);
  c_read_ack: cover property (read && !waitrequest);
  c_relay_make: cover property ($rose(relay_out[0]));
  c_irq_rise: cover property ($rose(irq));
endmodule

bind setpoint_relay_controller setpoint_relay_controller_properties #(
  .SECOND_CYCLES(SECOND_CYCLES)
) u_props (
  .clk(clk), .rst_n(rst_n), .reading_valid(reading_valid), .read(read),
  .write(write), .waitrequest(waitrequest), .readdata(readdata),
  .relay_out(relay_out), .indicator(indicator),
  .analog_level(analog_level), .irq(irq)
);

`default_nettype wire

// File: verification/setpoint_relay_controller_tb.sv
`default_nettype none

module setpoint_relay_controller_tb
  import setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic fitted = 1'b1;
  logic [READING_W-1:0] value = '0;
  logic reading_valid;
  logic module_present_pin;
  logic [READING_W-1:0] reading;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'h0;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [NUM_SP-1:0] relay_out;
  logic [NUM_SP-1:0] indicator;
  logic [LEVEL_W-1:0] analog_level;
  logic irq;
  int fail_count = 0;
  int n_checks = 0;
  logic signed [15:0] sp [4] = '{16'sh0032, 16'sh0064, 16'sh00c8, 16'sh012c};
  logic signed [15:0] rds [5] = '{16'shff9c, 16'sh004b, 16'sh0096,
                                  16'sh00fa, 16'sh0190};
  logic signed [15:0] bnd [2][4] = '{'{16'shff9c, 16'sh004b, 16'sh0078,
      16'sh004b}, '{16'sh0078, 16'sh004b, 16'shff9c, 16'sh004b}};
  logic [3:0] pats [4] = '{PATTERN_LLLL, PATTERN_LHLH, PATTERN_LHHH,
                           PATTERN_HHHH};

  setpoint_relay_controller #(.SECOND_CYCLES(10)) dut (
    .clk(clk), .rst_n(rst_n), .reading_valid(reading_valid),
    .reading(reading), .module_present_pin(module_present_pin),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .relay_out(relay_out), .indicator(indicator),
    .analog_level(analog_level), .irq(irq)
  );
  conversion_source src (
    .clk(clk), .rst_n(rst_n), .go(go), .value(value), .fitted(fitted),
    .reading_valid(reading_valid), .reading(reading),
    .module_present_pin(module_present_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial forever #10 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    byteenable <= 4'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // one result, then enough idle edges for relay one to settle
  task automatic conv(input logic [15:0] v, input int n = 1);
    repeat (n) begin
      @(posedge clk);
      go <= 1'b1;
      value <= v;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  function automatic logic [3:0] exp_rel(logic [3:0] pat,
                                         logic signed [15:0] r);
    for (int i = 0; i < 4; i++)
      exp_rel[i] = pat[3 - i] ? (r > sp[i]) : (r < sp[i]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(REG_CONTROL, 32'h000000f0);
    rdc(REG_SETPOINT_ONE, 32'h0000270f);
    rdc(REG_OUTPUT_LOW, 32'h00000fa0);
    rdc(4'he, 32'h00000000);
    rdc(REG_STATUS, 32'h00000100);
    wr(REG_CONTROL, 32'h00000030);
    rdc(REG_CONTROL, 32'h000000f0);
    rdc(REG_IRQ_STATUS, 32'h00000002);
    check(32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h00000006);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h1);
    wr(REG_OUTPUT_HIGH, 32'h00007530);
    wr(REG_OUTPUT_HIGH, 32'h00000fa0);
    rdc(REG_OUTPUT_HIGH, 32'h00004e20);
    wr(REG_OUTPUT_HIGH, 32'h00004650);
    rdc(REG_OUTPUT_HIGH, 32'h00004650);
    wr(REG_CONTROL, 32'h000000f2);
    wr(REG_OUTPUT_HIGH, 32'h00002710);
    rdc(REG_OUTPUT_HIGH, 32'h00002710);
    wr(REG_CONTROL, 32'h000000f0);
    wr(REG_OUTPUT_HIGH, 32'h00004e20);
    rdc(REG_IRQ_STATUS, 32'h00000006);
    wr(REG_IRQ_STATUS, 32'h00000006);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0);
    for (int i = 0; i < 4; i++) wr(4'(i + 1), {16'h0, sp[i]});
    for (int p = 0; p < 4; p++) begin
      wr(REG_CONTROL, {24'h0, pats[p], 4'h0});
      for (int k = 0; k < 5; k++) begin
        conv(rds[k]);
        check(32'(relay_out), 32'(exp_rel(pats[p], rds[k])));
        check(32'(indicator), 32'(exp_rel(pats[p], rds[k])));
      end
    end
    for (int p = 0; p < 2; p++) begin
      wr(REG_CONTROL, p ? 32'h000000f1 : 32'h00000051);
      for (int k = 0; k < 4; k++) begin
        conv(bnd[p][k]);
        check(32'(relay_out[0]), 32'(k < 2));
      end
    end
    wr(REG_CONTROL, 32'h000000f0);
    wr(REG_MAKE_DELAY, 32'h00002710);
    rdc(REG_MAKE_DELAY, 32'h00000000);
    wr(REG_MAKE_DELAY, 32'h00000002);
    wr(REG_BREAK_DELAY, 32'h00000002);
    conv(16'h0064);
    check(32'(relay_out[0]), 32'h0);
    conv(16'h0064, 6);
    check(32'(relay_out[0]), 32'h1);
    conv(16'h0000);
    conv(16'h0064, 2);
    conv(16'h0000);
    check(32'(relay_out[0]), 32'h1);
    conv(16'h0000, 8);
    check(32'(relay_out[0]), 32'h0);
    wr(REG_SPAN_HIGH, 32'h000003e8);
    conv(16'h01f4);
    check(32'(analog_level), 32'h00002ee0);
    conv(16'hff9c);
    check(32'(analog_level), 32'h00000fa0);
    conv(16'h044c);
    check(32'(analog_level), 32'h00005460);
    wr(REG_SPAN_HIGH, 32'h00000000);
    wr(REG_SPAN_LOW, 32'h000003e8);
    conv(16'h00fa);
    check(32'(analog_level), 32'h00003e80);
    fitted <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(REG_STATUS, 32'h00000000);
    wr(REG_OUTPUT_LOW, 32'h00001000);
    rdc(REG_OUTPUT_LOW, 32'h00000fa0);
    conv(16'h01f4);
    check(32'(analog_level), 32'h00000000);
    report_and_stop();
  end
endmodule

`default_nettype wire
